//--- scc_spindle_contactor_coil.v
// spindle drive sequencing: contactor on/off, speed detect with hysteresis,
// coil changeover blanking and post-switch current limit, input/output function map.
// assumes all pin inputs are asynchronous; speed and settings come from clk-domain logic.
`timescale 1ns/1ps
`include "scc_regs.vh"
module scc_spindle_contactor_coil
#(
    parameter NGI        = 12,
    parameter NEO        = 8,
    parameter NCO        = 6,
    parameter FILT_CYC   = `SCC_FILT_CYCLES,
    parameter MS_CYC     = `SCC_MS_CYCLES,
    parameter ENC_PPR    = 1024
)
(
    // clock and reset
    input  wire              clk,
    input  wire              rst_n,
    // dedicated inputs: ready, emergency stop, spare (pins)
    input  wire              machine_ready_pin,
    input  wire              emergency_stop_input,
    input  wire              dedicated_spare_pin,
    // general inputs and their function codes
    input  wire [NGI-1:0]    general_inputs,
    input  wire [NGI*5-1:0]  input_function_select,
    // command word pins
    input  wire [11:0]       orient_cmd_pins,
    input  wire [11:0]       speed_cmd_pins,
    // encoder pins
    input  wire              enc_a_pin,
    input  wire              enc_b_pin,
    // motor state from the control loop
    input  wire [14:0]       motor_speed,
    input  wire              motor_standstill,
    // settings
    input  wire [1:0]        contactor_off_mode_setting,
    input  wire [15:0]       stop_delay_setting,
    input  wire [14:0]       speed_threshold_value,
    input  wire [9:0]        speed_hysteresis_value,
    input  wire [15:0]       winding_switch_blank_time,
    input  wire [15:0]       post_switch_limit_time,
    input  wire [6:0]        post_switch_limit_level,
    input  wire [NEO*5-1:0]  emitter_output_select,
    input  wire [NCO*5-1:0]  collector_output_select,
    // contactor and power stage
    output reg               contactor_on,
    output reg               power_stage_enable,
    output reg  [6:0]        current_limit_pct,
    // status
    output reg               speed_detect_flag,
    output reg               low_coil_selected,
    output reg               coil_changing,
    // filtered command words and encoder
    output reg  [11:0]       orient_cmd,
    output reg  [11:0]       speed_cmd,
    output reg  [9:0]        enc_position,
    output reg               encoder_power_en,
    // general outputs
    output reg  [NEO-1:0]    emitter_outputs,
    output reg  [NCO-1:0]    collector_outputs,
    // differential pulse feedback
    output reg               fb_a_p,
    output reg               fb_a_n,
    output reg               fb_b_p,
    output reg               fb_b_n
);

localparam NFI = 3 + NGI + 24 + 2;
localparam FW  = 20;
localparam integer  FILT_M1  = FILT_CYC - 1;
localparam integer  MS_M1    = MS_CYC - 1;
localparam [FW-1:0] FILT_MAX = FILT_M1[FW-1:0];
localparam [16:0]   MS_MAX   = MS_M1[16:0];

// contactor states, one-hot
localparam [4:0] ST_OFF   = 5'h01;
localparam [4:0] ST_CHG   = 5'h02;
localparam [4:0] ST_ON    = 5'h04;
localparam [4:0] ST_DECEL = 5'h08;
localparam [4:0] ST_DELAY = 5'h10;
// coil states, one-hot
localparam [2:0] CO_IDLE  = 3'h1;
localparam [2:0] CO_BLANK = 3'h2;
localparam [2:0] CO_LIMIT = 3'h4;

function [15:0] clamp_blank;
    input [15:0] v;
    begin
        if (v < `SCC_BLANK_MS_MIN)
            clamp_blank = `SCC_BLANK_MS_MIN;
        else if (v > `SCC_BLANK_MS_MAX)
            clamp_blank = `SCC_BLANK_MS_MAX;
        else
            clamp_blank = v;
    end
endfunction

function [NGI-1:0] fn_match;
    input [NGI*5-1:0] sel;
    input [4:0]       code;
    integer k;
    begin
        for (k = 0; k < NGI; k = k + 1)
            fn_match[k] = (sel[k*5 +: 5] == code);
    end
endfunction

function out_fn;
    input [4:0] code;
    input       sd;
    input       lc;
    input       ch;
    input       ct;
    input       cl;
    begin
        case (code)
            `SCC_FN_SPEED_DET:  out_fn = sd;
            `SCC_FN_CONTACTOR:  out_fn = ct;
            `SCC_FN_CURR_LIMIT: out_fn = cl;
            `SCC_FN_CHANGING:   out_fn = ch;
            `SCC_FN_LOW_COIL:   out_fn = lc;
            default:            out_fn = 1'b0;
        endcase
    end
endfunction

// two-flop synchronisers for every pin input
wire [NFI-1:0] raw_in = {enc_b_pin, enc_a_pin, speed_cmd_pins, orient_cmd_pins, general_inputs,
                         dedicated_spare_pin, emergency_stop_input, machine_ready_pin};
reg  [NFI-1:0] sync1_r;
reg  [NFI-1:0] sync2_r;
always @(posedge clk)
begin
    if (!rst_n)
    begin
        sync1_r <= {NFI{1'b0}};
        sync2_r <= {NFI{1'b0}};
    end
    else
    begin
        sync1_r <= raw_in;
        sync2_r <= sync1_r;
    end
end

// input filter stage
// a level must hold for the full filter time before it is accepted
reg [NFI-1:0] filt_r;
reg [FW-1:0]  fcnt_r [0:NFI-3];
integer i;
always @(posedge clk)
begin
    for (i = 0; i < NFI-2; i = i + 1)
    begin
        if (!rst_n)
        begin
            fcnt_r[i] <= {FW{1'b0}};
            filt_r[i] <= 1'b0;
        end
        else if (sync2_r[i] == filt_r[i])
            fcnt_r[i] <= {FW{1'b0}};
        else if (fcnt_r[i] == FILT_MAX)
        begin
            fcnt_r[i] <= {FW{1'b0}};
            filt_r[i] <= sync2_r[i];
        end
        else
            fcnt_r[i] <= fcnt_r[i] + 1'b1;
    end
    // encoder lines are fast; they are only synchronised, not filtered
    if (!rst_n)
        filt_r[NFI-1:NFI-2] <= 2'b00;
    else
        filt_r[NFI-1:NFI-2] <= sync2_r[NFI-1:NFI-2];
end

wire          rdy_f  = filt_r[0];
wire          emg_f  = filt_r[1];
wire [NGI-1:0] gin_f = filt_r[3 +: NGI];

// low coil select from whichever general input carries code 18
wire low_coil_select_cmd = |(gin_f & fn_match(input_function_select, `SCC_FN_LOW_COIL));

// millisecond tick
reg [16:0] ms_cnt_r;
reg        ms_tick_r;
always @(posedge clk)
begin
    if (!rst_n || ms_cnt_r == MS_MAX)
        ms_cnt_r <= 17'h00000;
    else
        ms_cnt_r <= ms_cnt_r + 1'b1;
    ms_tick_r <= rst_n && (ms_cnt_r == MS_MAX);
end

// contactor sequence
reg [4:0]  cst_r;
reg [15:0] cms_r;
always @(posedge clk)
begin
    if (!rst_n)
    begin
        cst_r        <= ST_OFF;
        cms_r        <= 16'h0000;
        contactor_on <= 1'b0;
    end
    else if (!rdy_f)
    begin
        cst_r        <= ST_OFF;
        contactor_on <= 1'b0;
    end
    else
    begin
        case (cst_r)
            ST_OFF:
                if (!emg_f)
                    cst_r <= ST_CHG;
            ST_CHG:
            begin
                contactor_on <= 1'b1;
                cst_r        <= ST_ON;
            end
            ST_ON:
                if (emg_f)
                    cst_r <= ST_DECEL;
            ST_DECEL:
                if (!emg_f)
                    cst_r <= ST_ON;
                else if (motor_standstill && contactor_off_mode_setting[1] == 1'b0)
                begin
                    cms_r <= 16'h0000;
                    cst_r <= ST_DELAY;
                end
            ST_DELAY:
                if (!emg_f)
                    cst_r <= ST_ON;
                else if (cms_r >= stop_delay_setting)
                begin
                    contactor_on <= 1'b0;
                    cst_r        <= ST_OFF;
                end
                else if (ms_tick_r)
                    cms_r <= cms_r + 1'b1;
            default:
                cst_r <= ST_OFF;
        endcase
    end
end

// hysteresis band below the threshold for release
wire [15:0] rel_lvl = {1'b0, speed_threshold_value} - {6'h00, speed_hysteresis_value};
always @(posedge clk)
begin
    if (!rst_n)
        speed_detect_flag <= 1'b0;
    else if (motor_speed >= speed_threshold_value)
        speed_detect_flag <= 1'b1;
    // a band wider than the threshold has no release level: the flag then holds
    else if (!rel_lvl[15] && {1'b0, motor_speed} < rel_lvl)
        speed_detect_flag <= 1'b0;
end

// coil changeover; the host toggles the select after seeing the flag
reg [2:0]  co_r;
reg [15:0] co_ms_r;
always @(posedge clk)
begin
    if (!rst_n)
    begin
        co_r               <= CO_IDLE;
        co_ms_r            <= 16'h0000;
        low_coil_selected  <= 1'b0;
        coil_changing      <= 1'b0;
        power_stage_enable <= 1'b0;
        current_limit_pct  <= `SCC_FULL_CURRENT;
    end
    else
    begin
        // restart blanking on any select change
        if (low_coil_select_cmd != low_coil_selected)
        begin
            low_coil_selected  <= low_coil_select_cmd;
            co_ms_r            <= 16'h0000;
            co_r               <= CO_BLANK;
            coil_changing      <= 1'b1;
            power_stage_enable <= 1'b0;
        end
        else
        begin
            case (co_r)
                CO_IDLE:
                begin
                    power_stage_enable <= contactor_on;
                    current_limit_pct  <= `SCC_FULL_CURRENT;
                end
                CO_BLANK:
                    if (co_ms_r >= clamp_blank(winding_switch_blank_time))
                    begin
                        coil_changing      <= 1'b0;
                        power_stage_enable <= contactor_on;
                        co_ms_r            <= 16'h0000;
                        co_r               <= CO_LIMIT;
                    end
                    else if (ms_tick_r)
                        co_ms_r <= co_ms_r + 1'b1;
                CO_LIMIT:
                begin
                    power_stage_enable <= contactor_on;
                    current_limit_pct  <= post_switch_limit_level;
                    if (co_ms_r >= post_switch_limit_time)
                        co_r <= CO_IDLE;
                    else if (ms_tick_r)
                        co_ms_r <= co_ms_r + 1'b1;
                end
                default:
                    co_r <= CO_IDLE;
            endcase
        end
    end
end

// quadrature position, power supplied from this side from the first clock after reset
reg [1:0] enc_prev_r;
always @(posedge clk)
begin
    if (!rst_n)
    begin
        enc_prev_r       <= 2'b00;
        enc_position     <= 10'h000;
        encoder_power_en <= 1'b0;
    end
    else
    begin
        encoder_power_en <= 1'b1;
        enc_prev_r       <= filt_r[NFI-1:NFI-2];
        if (enc_prev_r[0] != filt_r[NFI-2])
        begin
            if (filt_r[NFI-2] ^ filt_r[NFI-1])
                enc_position <= enc_position + 1'b1;
            else
                enc_position <= enc_position - 1'b1;
        end
    end
end

integer j;
always @(posedge clk)
begin
    if (!rst_n)
    begin
        emitter_outputs   <= {NEO{1'b0}};
        collector_outputs <= {NCO{1'b0}};
        orient_cmd        <= 12'h000;
        speed_cmd         <= 12'h000;
        fb_a_p            <= 1'b0;
        fb_a_n            <= 1'b1;
        fb_b_p            <= 1'b0;
        fb_b_n            <= 1'b1;
    end
    else
    begin
        for (j = 0; j < NEO; j = j + 1)
            emitter_outputs[j] <= out_fn(emitter_output_select[j*5 +: 5], speed_detect_flag,
                                         low_coil_selected, coil_changing, contactor_on,
                                         co_r == CO_LIMIT);
        for (j = 0; j < NCO; j = j + 1)
            collector_outputs[j] <= out_fn(collector_output_select[j*5 +: 5], speed_detect_flag,
                                           low_coil_selected, coil_changing, contactor_on,
                                           co_r == CO_LIMIT);
        orient_cmd <= filt_r[3+NGI +: 12];
        speed_cmd  <= filt_r[15+NGI +: 12];
        fb_a_p     <= filt_r[NFI-2];
        fb_a_n     <= ~filt_r[NFI-2];
        fb_b_p     <= filt_r[NFI-1];
        fb_b_n     <= ~filt_r[NFI-1];
    end
end

endmodule

//--- scc_regs.vh
// timing, code and reset constants for the spindle contactor and coil logic
// assumes a 100 MHz clock; the filter time and the millisecond are converted to clock cycles by the macros below, the other times stay in ms
`ifndef SCC_REGS_VH
`define SCC_REGS_VH
`define SCC_CLK_MHZ          100
`define SCC_FILT_US          10000
`define SCC_MS_CYCLES        (`SCC_CLK_MHZ * 1000)
`define SCC_FILT_CYCLES      (`SCC_CLK_MHZ * `SCC_FILT_US)
`define SCC_BLANK_MS_MIN     16'h0032
`define SCC_BLANK_MS_MAX     16'h2710
`define SCC_BLANK_MS_RST     16'h0096
`define SCC_LIMIT_MS_RST     16'h01F4
`define SCC_LIMIT_PCT_RST    7'h4B
`define SCC_STOP_MS_RST      16'h0000
`define SCC_THRESH_MAX       15'h7FFF
`define SCC_HYST_MAX         10'h3E8
`define SCC_HYST_RST         10'h064
`define SCC_FN_LOW_COIL      5'h12
`define SCC_FN_CHANGING      5'h10
`define SCC_FN_SPEED_DET     5'h03
`define SCC_FN_CONTACTOR     5'h04
`define SCC_FN_CURR_LIMIT    5'h07
`define SCC_FULL_CURRENT     7'h64
`endif

//--- scc_props.sv
// checker: contactor, speed detect, changeover and output map relations
// assumes bind to the drive top with a short input filter (about 8 cycles)
`timescale 1ns/1ps
module scc_props #(parameter NEO = 8, parameter NCO = 6)
(
    // clock and reset
    input wire logic            clk,
    input wire logic            rst_n,
    // inputs watched
    input wire logic            machine_ready_pin,
    input wire logic [14:0]     motor_speed,
    input wire logic [14:0]     speed_threshold_value,
    input wire logic [9:0]      speed_hysteresis_value,
    input wire logic [1:0]      contactor_off_mode_setting,
    input wire logic [6:0]      post_switch_limit_level,
    input wire logic [NEO*5-1:0] emitter_output_select,
    input wire logic [NCO*5-1:0] collector_output_select,
    // outputs watched
    input wire logic            contactor_on,
    input wire logic            power_stage_enable,
    input wire logic [6:0]      current_limit_pct,
    input wire logic            speed_detect_flag,
    input wire logic            low_coil_selected,
    input wire logic            coil_changing,
    input wire logic [NEO-1:0]  emitter_outputs,
    input wire logic [NCO-1:0]  collector_outputs,
    input wire logic            fb_a_p,
    input wire logic            fb_a_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ready gone for longer than sync plus filter
    sequence s_ready_gone;
        !machine_ready_pin [*8] ##1 !machine_ready_pin [*8];
    endsequence
    sequence s_blank_end;
        $fell(coil_changing) ##0 contactor_on;
    endsequence
    a_on_needs_ready: assert property ($rose(contactor_on) |-> $past(machine_ready_pin, 3))
        else $error("contactor closed without ready");
    a_ready_low_off: assert property (s_ready_gone |-> ##[0:3] !contactor_on)
        else $error("contactor held after ready loss");
    a_mode_keeps_on: assert property (contactor_off_mode_setting[1] && machine_ready_pin && contactor_on |=> contactor_on)
        else $error("contactor opened in keep mode");
    a_blank_stage_off: assert property (coil_changing |-> !power_stage_enable)
        else $error("power stage on while blanking");
    a_coil_flags: assert property ($changed(low_coil_selected) |-> coil_changing)
        else $error("coil change without changing flag");
    a_limit_after: assert property (s_blank_end |-> ##[0:1] current_limit_pct == post_switch_limit_level)
        else $error("no current limit after blanking");
    a_detect_set: assert property ($rose(speed_detect_flag) |-> $past(motor_speed) >= $past(speed_threshold_value))
        else $error("speed flag set below threshold");
    a_detect_rise: assert property (!speed_detect_flag && motor_speed >= speed_threshold_value |=> speed_detect_flag)
        else $error("speed flag missing");
    a_detect_clr: assert property ($fell(speed_detect_flag) |->
        ({2'b0, $past(motor_speed)} + $past(speed_hysteresis_value)) < $past(speed_threshold_value))
        else $error("speed flag cleared inside hysteresis");
    a_out_low_coil: assert property (emitter_output_select[4:0] == 5'h12 && $stable(low_coil_selected)
        |-> emitter_outputs[0] == low_coil_selected)
        else $error("low coil output mismatch");
    a_out_changing: assert property (collector_output_select[4:0] == 5'h10 && $stable(coil_changing)
        |-> collector_outputs[0] == coil_changing)
        else $error("changing output mismatch");
    a_fb_diff: assert property (fb_a_p != fb_a_n)
        else $error("feedback pair not complementary");
endmodule

//--- scc_host_model.sv
// host controller model: drives ready, emergency stop and low coil select
// assumes bench commands and the drive's speed flag in the clk domain
`timescale 1ns/1ps
module scc_host_model
(
    // clock
    input  wire logic clk,
    // bench commands
    input  wire logic ready_cmd,
    input  wire logic emg_cmd,
    input  wire logic coil_auto,
    input  wire logic coil_cmd,
    // drive status
    input  wire logic speed_detect_flag,
    // pins to the drive
    output logic      machine_ready_pin = 1'b0,
    output logic      emergency_stop_input = 1'b0,
    output logic      low_coil_pin = 1'b0
);
    always @(posedge clk)
    begin
        machine_ready_pin    <= ready_cmd;
        emergency_stop_input <= emg_cmd;
        low_coil_pin         <= coil_auto ? !speed_detect_flag : coil_cmd;
    end
endmodule

//--- tb_spindle_contactor_coil_control.sv
// testbench: drive sequencing, speed detect, changeover and output map
// assumes filter 8 cycles and 4 cycles a millisecond
`timescale 1ns/1ps
module tb_spindle_contactor_coil_control;
    logic clk, rst_n, ready_cmd, emg_cmd, coil_auto, coil_cmd, standstill, enc;
    logic machine_ready_pin, emergency_stop_input, low_coil_pin;
    logic [10:0] gen_hi;
    logic [14:0] speed;
    logic [1:0]  mode;
    logic contactor_on, power_stage_enable, speed_detect_flag, low_coil_selected, coil_changing;
    logic [6:0]  current_limit_pct;
    logic [7:0]  emitter_outputs;
    logic [5:0]  collector_outputs;
    logic encoder_power_en, fb_a_p, fb_a_n, fb_b_p, fb_b_n, nb;
    logic [11:0] orient, spd_pins, orient_cmd, speed_cmd;
    logic [9:0]  enc_position, hyst = 10'h064;
    logic [14:0] thr = 15'h03E8;
    logic [15:0] blank_ms = 16'h0010, lim_ms = 16'h000A;
    logic [6:0]  lim_pct = 7'h4B;
    int err_count = 0, num_checks = 0, cyc = 0, n, r, exp_flag = 0, exp_pos = 0;

    scc_host_model host (.clk(clk), .ready_cmd(ready_cmd), .emg_cmd(emg_cmd), .coil_auto(coil_auto),
        .coil_cmd(coil_cmd), .speed_detect_flag(speed_detect_flag), .machine_ready_pin(machine_ready_pin),
        .emergency_stop_input(emergency_stop_input), .low_coil_pin(low_coil_pin));

    scc_spindle_contactor_coil #(.FILT_CYC(8), .MS_CYC(4)) uut (.clk(clk), .rst_n(rst_n),
        .machine_ready_pin(machine_ready_pin), .emergency_stop_input(emergency_stop_input),
        .dedicated_spare_pin(1'b0), .general_inputs({gen_hi, low_coil_pin}), .input_function_select({55'h0, 5'h12}),
        .orient_cmd_pins(orient), .speed_cmd_pins(spd_pins), .enc_a_pin(enc), .enc_b_pin(!enc),
        .motor_speed(speed), .motor_standstill(standstill), .contactor_off_mode_setting(mode),
        .stop_delay_setting(16'h0005), .speed_threshold_value(thr), .speed_hysteresis_value(hyst),
        .winding_switch_blank_time(blank_ms), .post_switch_limit_time(lim_ms), .post_switch_limit_level(lim_pct),
        .emitter_output_select({15'h0, 5'h10, 5'h07, 5'h03, 5'h04, 5'h12}),
        .collector_output_select({20'h0, 5'h12, 5'h10}), .contactor_on(contactor_on),
        .power_stage_enable(power_stage_enable), .current_limit_pct(current_limit_pct),
        .speed_detect_flag(speed_detect_flag), .low_coil_selected(low_coil_selected),
        .coil_changing(coil_changing), .orient_cmd(orient_cmd), .speed_cmd(speed_cmd), .enc_position(enc_position),
        .encoder_power_en(encoder_power_en), .emitter_outputs(emitter_outputs),
        .collector_outputs(collector_outputs), .fb_a_p(fb_a_p), .fb_a_n(fb_a_n), .fb_b_p(fb_b_p), .fb_b_n(fb_b_n));

    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task results;
        if (err_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // bounded wait: s 0 watches the contactor, 1 the changing flag
    task wt(input int s, input logic v);
        for (n = 0; n < 400; n++)
        begin
            @(posedge clk);
            #1;
            if ((s == 0 ? contactor_on : coil_changing) === v)
                break;
        end
    endtask

    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            results();
        end
    end

    initial
    begin
        {rst_n, ready_cmd, emg_cmd, coil_auto, coil_cmd, standstill, enc, gen_hi, speed, mode, orient, spd_pins} = '0;
        void'($urandom(67));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        lim_pct <= 7'($urandom_range(90, 50));
        orient <= 12'($urandom);
        spd_pins <= 12'($urandom);
        @(posedge clk);
        #1;
        chk(encoder_power_en, 1);
        chk(current_limit_pct, 7'h64);
        @(posedge clk);
        ready_cmd <= 1'b1;
        wt(0, 1);
        chk(contactor_on, 1);
        // mapped outputs are registered one clock behind their source
        @(posedge clk);
        #1;
        chk(emitter_outputs[1], 1);
        // short ready dip must be swallowed by the filter
        @(posedge clk);
        ready_cmd <= 1'b0;
        repeat (3) @(posedge clk);
        ready_cmd <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        chk(contactor_on, 1);
        for (int i = 0; i < 40; i++)
        begin
            r = $urandom_range(1400, 600);
            @(posedge clk);
            speed <= r[14:0];
            gen_hi <= 11'($urandom);
            nb = 1'($urandom);
            if (nb != enc)
                exp_pos++;
            enc <= nb;
            repeat (4) @(posedge clk);
            #1;
            if (r >= 1000)
                exp_flag = 1;
            else if (r + 100 < 1000)
                exp_flag = 0;
            chk(speed_detect_flag, exp_flag);
            chk(emitter_outputs[2], exp_flag);
        end
        @(posedge clk);
        speed <= 15'h01F4;
        coil_auto <= 1'b1;
        wt(1, 1);
        chk(low_coil_selected, 1);
        chk(power_stage_enable, 0);
        chk(enc_position, exp_pos[9:0]);
        chk({fb_a_p, fb_a_n, fb_b_p, fb_b_n}, {enc, !enc, !enc, enc});
        chk(orient_cmd, orient);
        chk(speed_cmd, spd_pins);
        // blank setting below the minimum is raised to 50 ms
        wt(1, 0);
        chk(n >= 197 && n <= 202, 1);
        chk(power_stage_enable, 1);
        @(posedge clk);
        #1;
        chk(current_limit_pct, lim_pct);
        chk(emitter_outputs[3], 1);
        repeat (45) @(posedge clk);
        #1;
        chk(current_limit_pct, 7'h64);
        @(posedge clk);
        speed <= 15'h05DC;
        wt(1, 1);
        chk(low_coil_selected, 0);
        wt(1, 0);
        @(posedge clk);
        emg_cmd <= 1'b1;
        repeat (30) @(posedge clk);
        #1;
        chk(contactor_on, 1);
        @(posedge clk);
        standstill <= 1'b1;
        wt(0, 0);
        chk(n >= 18 && n <= 21, 1);
        @(posedge clk);
        emg_cmd <= 1'b0;
        standstill <= 1'b0;
        wt(0, 1);
        chk(contactor_on, 1);
        @(posedge clk);
        mode <= 2'h2;
        emg_cmd <= 1'b1;
        standstill <= 1'b1;
        repeat (60) @(posedge clk);
        #1;
        chk(contactor_on, 1);
        @(posedge clk);
        ready_cmd <= 1'b0;
        wt(0, 0);
        chk(n <= 16, 1);
        results();
    end
endmodule

bind scc_spindle_contactor_coil scc_props #(.NEO(NEO), .NCO(NCO)) u_props (.clk(clk), .rst_n(rst_n),
    .machine_ready_pin(machine_ready_pin), .motor_speed(motor_speed), .speed_threshold_value(speed_threshold_value),
    .speed_hysteresis_value(speed_hysteresis_value), .contactor_off_mode_setting(contactor_off_mode_setting),
    .post_switch_limit_level(post_switch_limit_level), .emitter_output_select(emitter_output_select),
    .collector_output_select(collector_output_select), .contactor_on(contactor_on),
    .power_stage_enable(power_stage_enable), .current_limit_pct(current_limit_pct),
    .speed_detect_flag(speed_detect_flag), .low_coil_selected(low_coil_selected), .coil_changing(coil_changing),
    .emitter_outputs(emitter_outputs), .collector_outputs(collector_outputs), .fb_a_p(fb_a_p), .fb_a_n(fb_a_n));
